//--- src/cls_defines.svh
// Constants for the configurable logic step sequencer: bus offsets,
// field positions, source selector codes, function codes and timing.
// Assumes a 50 MHz system clock and a byte-addressed register bus.
`ifndef CLS_DEFINES_SVH
`define CLS_DEFINES_SVH

// Register map (byte addresses, one 32-bit word each)
`define CLS_ADDR_STATUS 10'h000
`define CLS_ADDR_SOURCES 10'h004
`define CLS_STEP_BASE_HI 2'h1
`define CLS_REG_SEL_ONE 2'h0
`define CLS_REG_SEL_TWO 2'h1
`define CLS_REG_FUNC 2'h2
`define CLS_REG_SETTING 2'h3
`define CLS_NUM_STEPS 4'ha

// Source selector codes (decimal 2001, 2010, 4001, 4007, 4010, 4011,
// 6000, 6007) and the inverting offset (decimal 1000)
`define CLS_SEL_STEP_FIRST 16'h07d1
`define CLS_SEL_STEP_LAST 16'h07da
`define CLS_SEL_TERM_FIRST 16'h0fa1
`define CLS_SEL_TERM_LAST 16'h0fa7
`define CLS_SEL_FWD 16'h0faa
`define CLS_SEL_REV 16'h0fab
`define CLS_SEL_FLAG_FIRST 16'h1770
`define CLS_SEL_FLAG_LAST 16'h1777
`define CLS_SEL_INVERT 16'h03e8

// Function selector codes
`define CLS_FN_OFF 4'h0
`define CLS_FN_THROUGH 4'h1
`define CLS_FN_AND 4'h2
`define CLS_FN_OR 4'h3
`define CLS_FN_XOR 4'h4
`define CLS_FN_SET_FF 4'h5
`define CLS_FN_RST_FF 4'h6
`define CLS_FN_RISE 4'h7
`define CLS_FN_FALL 4'h8
`define CLS_FN_BOTH 4'h9
`define CLS_FN_HOLD 4'ha
`define CLS_FN_UP 4'hb
`define CLS_FN_DOWN 4'hc
`define CLS_FN_TIMER 4'hd

// Setting in hundredths, 0.00 to 600.00 (decimal 60000)
`define CLS_SETTING_MAX 16'hea60
`define CLS_SETTING_RESET 16'h0000
`define CLS_SEL_RESET 16'h0000
`define CLS_FUNC_RESET 4'h0

// Timing: evaluation tick and timer resolution
`define CLS_CLK_KHZ 50000
`define CLS_TICK_MS 2
`define CLS_TICK_CYCLES (`CLS_TICK_MS * `CLS_CLK_KHZ)
`define CLS_SETTING_UNIT_US 10000
`define CLS_TICK_US (`CLS_TICK_MS * 1000)
`define CLS_TICKS_PER_UNIT (`CLS_SETTING_UNIT_US / `CLS_TICK_US)

`endif

//--- src/cls_pkg.sv
// Types shared by the configurable logic step sequencer.
// Constants live in cls_defines.svh; this package holds types only.
package cls_pkg;

  // Drive-side inputs: terminals and raw status
  typedef struct packed {
    logic [6:0] digital_input_terminal;
    logic forward_run_terminal;
    logic reverse_run_terminal;
    logic freq_cmd_nonzero;
    logic run_cmd;
    logic fwd_run_cmd;
    logic rev_run_cmd;
    logic accelerating;
    logic decelerating;
    logic anti_regen_active;
    logic dancer_in_range;
    logic alarm_present;
  } cls_drive_type;

  // Per-step configuration as software writes it
  typedef struct packed {
    logic [15:0] step_input_one_select;
    logic [15:0] step_input_two_select;
    logic [3:0] step_function_select;
    logic [15:0] step_period_or_count_setting;
  } cls_cfg_type;

endpackage : cls_pkg

//--- src/cls_sequencer.sv
// Ten-step configurable logic sequencer with an Avalon-MM register port.
// Assumes drive inputs synchronous to clk_sys and a master that holds
// each request until waitrequest falls.
//
// How it works
// [RULE1] Selector codes 2001-2010 take step one to ten outputs.
// [RULE2] Codes 4001-4007 pick terminals one-seven; 4010 forward, 4011 reverse.
// [RULE3] Codes 6000-6002: run flags, frequency nonzero with matching run.
// [RULE4] Codes 6003-6005: accelerating, decelerating, anti-regen flags.
// [RULE5] Code 6006: dancer position inside its reference range.
// [RULE6] Code 6007: alarm-factor flag, high when no alarm present.
// [RULE7] Function 0 holds the step output low always.
// [RULE8] Function 1 passes input one straight through.
// [RULE9] Functions 2, 3, 4 give AND, OR, XOR of both inputs.
// [RULE10] Function 5 is a set-priority flip-flop, input one sets.
// [RULE11] Function 6 is a reset-priority flip-flop, input two resets.
// [RULE12] Function 7 pulses one tick on each rising edge of input one.
// [RULE13] Function 8 pulses one tick on each falling edge.
// [RULE14] Function 9 pulses one tick on either edge.
// [RULE15] Function 10 follows input one unless input two holds it.
// [RULE16] Function 11 counts rising edges up, output at target, reset zeroes.
// [RULE17] Function 12 counts down, output at zero, reset reloads.
// [RULE18] Function 13 rising input starts timed pulse, ends at period.
// [RULE19] Timer reset input zeroes elapsed count and drops output.
// [RULE20] Set-priority: input one sets, input two alone clears, else holds.
// [RULE21] Reset-priority: input two clears, input one alone sets, else holds.
// [RULE22] Counter value is the setting in hundredths, range 0 to 60000.
// [RULE23] All steps evaluate together once every 2 ms tick.
// [RULE24] Codes plus 1000 select the same source inverted.
// [RULE25] Edges compare against the sample from the previous tick.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cls_defines.svh"

module cls_sequencer #(
  parameter int TICK_CYCLES = `CLS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Drive terminals and status
  input wire cls_pkg::cls_drive_type drive_in,
  // Step results
  output logic [9:0] step_result,
  output logic eval_tick
);
  import cls_pkg::*;

  // Source flags in selector order, code 6000 upward
  logic [7:0] drive_flags;
  logic [9:0] step_q;
  logic [31:0] tick_cnt;
  logic tick;
  cls_cfg_type cfg [10];

  // Status flags derived from the raw drive signals
  assign drive_flags[0] = drive_in.freq_cmd_nonzero
                          & drive_in.run_cmd; // [RULE3]
  assign drive_flags[1] = drive_in.freq_cmd_nonzero
                          & drive_in.fwd_run_cmd; // [RULE3]
  assign drive_flags[2] = drive_in.freq_cmd_nonzero
                          & drive_in.rev_run_cmd; // [RULE3]
  assign drive_flags[3] = drive_in.accelerating; // [RULE4]
  assign drive_flags[4] = drive_in.decelerating; // [RULE4]
  assign drive_flags[5] = drive_in.anti_regen_active; // [RULE4]
  assign drive_flags[6] = drive_in.dancer_in_range; // [RULE5]
  // Documented polarity: high while no alarm factor is present
  assign drive_flags[7] = ~drive_in.alarm_present; // [RULE6]

  // Look up a plain (non-inverted) code; returns {valid, value}.
  // Terminals come in as an argument so that the continuous assignments
  // calling this re-evaluate whenever a terminal moves.
  function automatic logic [1:0] cls_lookup(
    input logic [15:0] code,
    input logic [9:0] so,
    input logic [7:0] fl,
    input cls_drive_type dv
  );
    logic [15:0] d;
    logic [1:0] r;
    r = 2'h0;
    d = 16'h0000;
    if (code >= `CLS_SEL_STEP_FIRST && code <= `CLS_SEL_STEP_LAST) begin
      d = code - `CLS_SEL_STEP_FIRST;
      r = {1'b1, so[d[3:0]]}; // [RULE1]
    end else if (code >= `CLS_SEL_TERM_FIRST &&
                 code <= `CLS_SEL_TERM_LAST) begin
      d = code - `CLS_SEL_TERM_FIRST;
      r = {1'b1, dv.digital_input_terminal[d[2:0]]}; // [RULE2]
    end else if (code == `CLS_SEL_FWD) begin
      r = {1'b1, dv.forward_run_terminal}; // [RULE2]
    end else if (code == `CLS_SEL_REV) begin
      r = {1'b1, dv.reverse_run_terminal}; // [RULE2]
    end else if (code >= `CLS_SEL_FLAG_FIRST &&
                 code <= `CLS_SEL_FLAG_LAST) begin
      d = code - `CLS_SEL_FLAG_FIRST;
      r = {1'b1, fl[d[2:0]]}; // [RULE3]
    end
    return r;
  endfunction : cls_lookup

  // Full selector: plain ranges, then the same ranges shifted and inverted.
  // Unknown codes read as low so a bad setting cannot assert anything.
  function automatic logic cls_pick(
    input logic [15:0] code,
    input logic [9:0] so,
    input logic [7:0] fl,
    input cls_drive_type dv
  );
    logic [1:0] plain;
    logic [1:0] shifted;
    logic v;
    plain = cls_lookup(code, so, fl, dv);
    shifted = cls_lookup(code - `CLS_SEL_INVERT, so, fl, dv);
    v = 1'b0;
    if (plain[1]) begin
      v = plain[0];
    end else if (shifted[1] && code >= `CLS_SEL_INVERT) begin
      v = ~shifted[0]; // [RULE24]
    end
    return v;
  endfunction : cls_pick

  // Evaluation tick: one cycle every TICK_CYCLES clocks
  wire tick_wrap = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      tick <= tick_wrap; // [RULE23]
    end
  end

  // Bus decode: status words low, step blocks at 0x100 + 0x10 * step
  logic bus_ack;
  wire bus_req = avs_read | avs_write;
  wire step_area = (avs_address[9:8] == `CLS_STEP_BASE_HI);
  wire [3:0] bus_step = avs_address[7:4];
  wire [1:0] bus_reg = avs_address[3:2];
  wire step_hit = step_area && (bus_step < `CLS_NUM_STEPS);
  wire wr_fire = avs_write & bus_ack;

  // One wait state: request sampled, then answered the next cycle
  assign avs_waitrequest = bus_req & ~bus_ack;

  // Read selection; unmapped addresses read as zero
  wire [31:0] sources_word = {15'h0000, drive_flags,
                              drive_in.reverse_run_terminal,
                              drive_in.forward_run_terminal,
                              drive_in.digital_input_terminal};
  cls_cfg_type rd_cfg;
  assign rd_cfg = step_hit ? cfg[bus_step] : '0;
  wire [31:0] step_word =
    (bus_reg == `CLS_REG_SEL_ONE) ? {16'h0000,
                                     rd_cfg.step_input_one_select} :
    (bus_reg == `CLS_REG_SEL_TWO) ? {16'h0000,
                                     rd_cfg.step_input_two_select} :
    (bus_reg == `CLS_REG_FUNC) ? {28'h000_0000,
                                  rd_cfg.step_function_select} :
    {16'h0000, rd_cfg.step_period_or_count_setting};
  wire [31:0] next_readdata =
    step_hit ? step_word :
    (avs_address == `CLS_ADDR_STATUS) ? {22'h00_0000, step_q} :
    (avs_address == `CLS_ADDR_SOURCES) ? sources_word :
    32'h0000_0000;

  // Bus answer: read data captured with the acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // Byte-lane merge of the low 16 bits of a write
  function automatic logic [15:0] cls_merge(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : cls_merge

  // One identical step per generate entry
  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : gen_step
      logic in1;
      logic in2;
      logic prev1;
      logic [15:0] cnt;
      logic [18:0] tmr;
      logic next_out;
      logic [15:0] next_cnt;
      logic [18:0] next_tmr;
      logic [15:0] set_merged;
      wire wr_here = wr_fire && step_hit && (bus_step == 4'(g));
      wire [15:0] target = cfg[g].step_period_or_count_setting; // [RULE22]
      // Timer period in ticks; setting counts hundredths of a second
      wire [18:0] period = 19'(target) * 19'(`CLS_TICKS_PER_UNIT);
      wire rise = in1 & ~prev1; // [RULE25]
      wire fall = ~in1 & prev1; // [RULE25]

      assign in1 = cls_pick(cfg[g].step_input_one_select,
                            step_q, drive_flags, drive_in);
      assign in2 = cls_pick(cfg[g].step_input_two_select,
                            step_q, drive_flags, drive_in);
      assign set_merged = cls_merge(cfg[g].step_period_or_count_setting,
                                    avs_writedata, avs_byteenable);

      // Configuration registers; settings above 600.00 are clamped
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cfg[g].step_input_one_select <= `CLS_SEL_RESET;
          cfg[g].step_input_two_select <= `CLS_SEL_RESET;
          cfg[g].step_function_select <= `CLS_FUNC_RESET;
          cfg[g].step_period_or_count_setting <= `CLS_SETTING_RESET;
        end else if (wr_here) begin
          case (bus_reg)
            `CLS_REG_SEL_ONE: begin
              cfg[g].step_input_one_select <= cls_merge(
                cfg[g].step_input_one_select, avs_writedata,
                avs_byteenable);
            end
            `CLS_REG_SEL_TWO: begin
              cfg[g].step_input_two_select <= cls_merge(
                cfg[g].step_input_two_select, avs_writedata,
                avs_byteenable);
            end
            `CLS_REG_FUNC: begin
              if (avs_byteenable[0]) begin
                cfg[g].step_function_select <= avs_writedata[3:0];
              end
            end
            default: begin
              cfg[g].step_period_or_count_setting <=
                (set_merged > `CLS_SETTING_MAX) ? `CLS_SETTING_MAX
                                                : set_merged; // [RULE22]
            end
          endcase
        end
      end

      // Step function; the output register doubles as flip-flop state
      always_comb begin
        next_out = 1'b0;
        next_cnt = cnt;
        next_tmr = 19'h0_0000;
        case (cfg[g].step_function_select)
          `CLS_FN_OFF: next_out = 1'b0; // [RULE7]
          `CLS_FN_THROUGH: next_out = in1; // [RULE8]
          `CLS_FN_AND: next_out = in1 & in2; // [RULE9]
          `CLS_FN_OR: next_out = in1 | in2; // [RULE9]
          `CLS_FN_XOR: next_out = in1 ^ in2; // [RULE9]
          `CLS_FN_SET_FF: begin
            next_out = in1 | (~in2 & step_q[g]); // [RULE10] [RULE20]
          end
          `CLS_FN_RST_FF: begin
            next_out = ~in2 & (in1 | step_q[g]); // [RULE11] [RULE21]
          end
          `CLS_FN_RISE: next_out = rise; // [RULE12]
          `CLS_FN_FALL: next_out = fall; // [RULE13]
          `CLS_FN_BOTH: next_out = rise | fall; // [RULE14]
          `CLS_FN_HOLD: next_out = in2 ? step_q[g] : in1; // [RULE15]
          `CLS_FN_UP: begin
            // Saturates at the target so the output stays on
            if (in2) begin
              next_cnt = 16'h0000; // [RULE16]
            end else if (rise && cnt < target) begin
              next_cnt = cnt + 16'h0001; // [RULE16]
            end
            next_out = (next_cnt >= target); // [RULE16]
          end
          `CLS_FN_DOWN: begin
            if (in2) begin
              next_cnt = target; // [RULE17]
            end else if (rise && cnt != 16'h0000) begin
              next_cnt = cnt - 16'h0001; // [RULE17]
            end
            next_out = (next_cnt == 16'h0000); // [RULE17]
          end
          `CLS_FN_TIMER: begin
            // Reset wins over a rising input in the same tick
            if (in2) begin
              next_out = 1'b0; // [RULE19]
              next_tmr = 19'h0_0000; // [RULE19]
            end else if (step_q[g]) begin
              // Running pulse ignores the input level until expiry
              if (tmr + 19'h0_0001 >= period) begin
                next_out = 1'b0; // [RULE18]
              end else begin
                next_out = 1'b1;
                next_tmr = tmr + 19'h0_0001;
              end
            end else if (rise) begin
              next_out = (period != 19'h0_0000); // [RULE18]
            end
          end
          default: next_out = 1'b0;
        endcase
      end

      // Evaluated once per tick from the previous tick's outputs
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          step_q[g] <= 1'b0;
          prev1 <= 1'b0;
          cnt <= 16'h0000;
          tmr <= 19'h0_0000;
        end else if (tick) begin
          step_q[g] <= next_out; // [RULE23]
          prev1 <= in1; // [RULE25]
          cnt <= next_cnt;
          tmr <= next_tmr;
        end
      end
    end
  endgenerate

  // Results leave straight from the step registers
  assign step_result = step_q;
  assign eval_tick = tick;

endmodule : cls_sequencer

//--- tb/cls_sequencer_asserts.sv
// Port-level checks of the logic step sequencer.
// Assumes binding onto cls_sequencer, with its TICK_CYCLES handed on.
`timescale 1ns/1ps
module cls_seq_asserts #(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Drive levels and results
  input wire cls_pkg::cls_drive_type drive_in,
  input wire logic [9:0] step_result,
  input wire logic eval_tick
);
  import cls_pkg::*;
  int cnt;
  logic seen;
  cls_drive_type dp;
  wire logic st_rd = avs_read && !avs_waitrequest && avs_address == 10'h004;

  // Cycles since the last tick; the first tick is skipped, its offset
  // from reset release being a design choice
  always_ff @(posedge clk_sys) begin
    dp <= drive_in;
    if (!rst_n) begin
      cnt <= 0;
      seen <= 1'b0;
    end else begin
      cnt <= eval_tick ? 1 : cnt + 1;
      seen <= seen | eval_tick;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_tick_pulse; eval_tick |=> !eval_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("tick pulse too long");
  property p_tick_period; seen |-> eval_tick == (cnt == TICK_CYCLES);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick period wrong");
  property p_result_on_tick; $changed(step_result) |-> $past(eval_tick);
  endproperty
  a_result_on_tick: assert property (p_result_on_tick)
    else $error("step result moved off tick");
  property p_status_terms; st_rd |-> avs_readdata[8:0] ==
    {dp.reverse_run_terminal, dp.forward_run_terminal,
     dp.digital_input_terminal}; endproperty
  a_status_terms: assert property (p_status_terms)
    else $error("terminal status wrong");
  property p_status_run; st_rd |-> avs_readdata[11:9] ==
    ({3{dp.freq_cmd_nonzero}} & {dp.rev_run_cmd, dp.fwd_run_cmd,
     dp.run_cmd}); endproperty
  a_status_run: assert property (p_status_run)
    else $error("run flags wrong");
  property p_status_motion; st_rd |-> avs_readdata[15:12] ==
    {dp.dancer_in_range, dp.anti_regen_active, dp.decelerating,
     dp.accelerating}; endproperty
  a_status_motion: assert property (p_status_motion)
    else $error("motion flags wrong");
  property p_status_alarm; st_rd |-> avs_readdata[16] != dp.alarm_present;
  endproperty
  a_status_alarm: assert property (p_status_alarm)
    else $error("alarm flag wrong");
  property p_one_wait; (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");
  property p_idle_wait; !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("wait while idle");
endmodule : cls_seq_asserts

bind cls_sequencer cls_seq_asserts #(.TICK_CYCLES(TICK_CYCLES))
  cls_seq_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .drive_in(drive_in), .step_result(step_result), .eval_tick(eval_tick));

//--- tb/cls_drive_model.sv
// Drive-side model: terminal levels and status flags.
// Assumes the bench loads new levels well away from evaluation ticks.
`timescale 1ns/1ps
module cls_drive_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench control
  input wire logic load,
  input wire cls_pkg::cls_drive_type value,
  // Levels toward the sequencer
  output cls_pkg::cls_drive_type drive_in
);
  import cls_pkg::*;
  // Levels move only on a load, like slow terminals and flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) drive_in <= '0;
    else if (load) drive_in <= value;
  end
endmodule : cls_drive_model

//--- tb/test_configurable_logic_step.sv
// Self-checking bench for the logic step sequencer.
// Assumes the design, its checker and the drive model compiled first.
`timescale 1ns/1ps
module test_configurable_logic_step;
  import cls_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] step_result;
  logic eval_tick;
  logic load = 1'b0;
  cls_drive_type value = '0;
  cls_drive_type drive_in;
  cls_drive_type cur = '0;
  logic [31:0] seed = 32'h00017f42;
  logic [31:0] expq [$];
  logic [3:0] fn [10];
  logic [15:0] st [10];
  logic [9:0] q;
  logic [9:0] pa;
  int cnt [10];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  cls_sequencer #(.TICK_CYCLES(20)) cls_sequencer_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_in(drive_in),
    .step_result(step_result), .eval_tick(eval_tick));
  cls_drive_model cls_drive_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .load(load), .value(value), .drive_in(drive_in));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Hang guard; the run needs about 3500 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: timeout", $time);
      complete_run();
    end
  end

  // Each read answer meets the oldest expected word
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      checks_done = checks_done + 1;
      if (expq.size() == 0 || avs_readdata !== expq.pop_front()) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: read %h", $time, avs_readdata);
      end
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Sources in selector order: terminals, run keys, then flags
  function automatic logic [16:0] status_of(input cls_drive_type d);
    return {!d.alarm_present, d.dancer_in_range, d.anti_regen_active,
      d.decelerating, d.accelerating, {3{d.freq_cmd_nonzero}} &
      {d.rev_run_cmd, d.fwd_run_cmd, d.run_cmd}, d.reverse_run_terminal,
      d.forward_run_terminal, d.digital_input_terminal};
  endfunction : status_of

  function automatic logic [15:0] sel_code(input int i);
    if (i < 7) return 16'h0fa1 + 16'(i);
    if (i < 9) return 16'h0fa3 + 16'(i);
    return 16'h1767 + 16'(i);
  endfunction : sel_code

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Request is held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic cfg(input int s, input logic [15:0] s1, input logic [15:0] s2,
                     input logic [3:0] f, input logic [15:0] v);
    logic [9:0] b;
    b = 10'h100 + 10'(s * 16);
    xfer(1'b1, b, {16'h0, s1});
    xfer(1'b1, b + 10'h4, {16'h0, s2});
    xfer(1'b1, b + 10'h8, {28'h0, f});
    xfer(1'b1, b + 10'hc, {16'h0, v});
    fn[s] = f;
    st[s] = v;
  endtask : cfg

  task automatic drive(input cls_drive_type v);
    value <= v;
    load <= 1'b1;
    cur = v;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask : drive

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (eval_tick !== 1'b1) @(posedge clk_sys);
    end
  endtask : tick

  task automatic do_reset();
    rst_n <= 1'b0;
    cur = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int s = 0; s < 10; s++) begin
      fn[s] = 4'h0;
      st[s] = 16'h0;
      cnt[s] = 0;
    end
    q = '0;
    pa = '0;
  endtask : do_reset

  // Random terminals one and two per tick, against a per-step model
  task automatic run(input int n);
    logic a;
    logic b;
    logic r;
    for (int t = 0; t < n; t++) begin
      seed = lfsr(seed);
      drive(cls_drive_type'(seed[17:0]));
      tick(1);
      a = cur.digital_input_terminal[0];
      b = cur.digital_input_terminal[1];
      for (int s = 0; s < 10; s++) begin
        r = a & !pa[s];
        case (fn[s])
          4'h1: q[s] = a;
          4'h2: q[s] = a & b;
          4'h3: q[s] = a | b;
          4'h4: q[s] = a ^ b;
          4'h5: q[s] = a | (q[s] & !b);
          4'h6: q[s] = !b & (a | q[s]);
          4'h7: q[s] = r;
          4'h8: q[s] = !a & pa[s];
          4'h9: q[s] = a ^ pa[s];
          4'ha: q[s] = b ? q[s] : a;
          4'hb: begin
            cnt[s] = b ? 0 : cnt[s] + r;
            q[s] = cnt[s] >= st[s];
          end
          4'hc: begin
            cnt[s] = b ? int'(st[s]) :
                     cnt[s] > 0 ? cnt[s] - r : 0;
            q[s] = cnt[s] == 0;
          end
          4'hd: begin
            cnt[s] = b ? 0 :
                     cnt[s] > 0 ? cnt[s] - 1 : r * st[s] * 5;
            q[s] = cnt[s] > 0;
          end
          default: q[s] = 1'b0;
        endcase
        pa[s] = a;
      end
      rd(10'h000, {22'h0, q});
    end
  endtask : run

  // Main sequence
  initial begin
    logic [16:0] sv;
    cls_drive_type v;
    do_reset();
    for (int s = 0; s < 10; s++) cfg(s, 16'h0fa1, 16'h0fa2, 4'(s + 1), 16'h0);
    run(40);
    $display("test functions one to ten done");
    do_reset();
    cfg(0, 16'h0fa1, 16'h0fa2, 4'hb, 16'h0003);
    cfg(1, 16'h0fa1, 16'h0fa2, 4'hc, 16'h0002);
    cfg(2, 16'h0fa1, 16'h0fa2, 4'hd, 16'h0001);
    cfg(3, 16'h0fa1, 16'h0fa2, 4'h0, 16'h0000);
    run(60);
    xfer(1'b1, 10'h13c, 32'h0000ffff);
    rd(10'h13c, 32'h0000ea60);
    rd(10'h3fc, 32'h0);
    rd(10'h108, 32'h0000000b);
    $display("test counters, timer and registers done");
    do_reset();
    cfg(0, 16'h0, 16'h0, 4'h1, 16'h0);
    for (int i = 0; i < 34; i++) begin
      xfer(1'b1, 10'h100,
           {16'h0, sel_code(i % 17) + (i > 16 ? 16'h03e8 : 16'h0)});
      seed = lfsr(seed);
      drive(cls_drive_type'(seed[17:0]));
      sv = status_of(cur);
      rd(10'h004, {15'h0, sv});
      tick(1);
      rd(10'h000, {31'h0, sv[i % 17] ^ (i > 16)});
    end
    $display("test input sources done");
    drive('0);
    cfg(0, 16'h0fa1, 16'h07da, 4'h3, 16'h0);
    for (int s = 1; s < 10; s++) cfg(s, 16'h07d0 + 16'(s), 16'h0, 4'h1, 16'h0);
    v = '0;
    v.digital_input_terminal = 7'h01;
    drive(v);
    tick(11);
    rd(10'h000, 32'h000003ff);
    drive('0);
    tick(11);
    rd(10'h000, 32'h000003ff);
    $display("test step chain done");
    complete_run();
  end
endmodule : test_configurable_logic_step
